// ==== hdl/irq_consts.svh ====
// Constants for the vectored interrupt arbiter
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

`define NUM_MASKABLE    10
`define ENTRY_ADDR      15'h00FF
`define ACK_CYCLES      3'h7
`define ADDR_ENABLE_LO  3'h0
`define ADDR_ENABLE_HI  3'h1
`define ADDR_PEND_LO    3'h2
`define ADDR_PEND_HI    3'h3
`define ADDR_STATUS     3'h4
`define ADDR_VECTOR     3'h5
`define STAT_GIE_BIT    0
`define VEC_TRAP        8'hFE
`define VEC_DEFAULT     8'hE0
`define VEC_TABLE       80'hE2_EA_EC_EE_F0_F2_F4_F6_F8_FA

`endif

// ==== hdl/irq_pkg.sv ====
// Types shared by the vectored interrupt arbiter
package irq_pkg;
    typedef logic [9:0]  src_vec_t;
    typedef logic [14:0] pc_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } ack_state_e;
endpackage

// ==== hdl/vectored_interrupt_arbiter.sv ====
// Interrupt enable, pending, arbitration and acknowledgment sequencer
`timescale 1ns/1ns
`include "irq_consts.svh"
module vectored_interrupt_arbiter (
    // Clock, reset, enable
    input  wire logic            ref_clk,
    input  wire logic            rst_b,
    input  wire logic            ce,
    // Register port
    input  wire logic [2:0]      addr,
    input  wire logic [7:0]      wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output logic [7:0]           rdata,
    // Source events, bit 0 ranks highest
    input  wire irq_pkg::src_vec_t src_event,
    input  wire logic            trap_exec,
    // Core sequencer
    input  wire logic            instr_start,
    input  wire logic            cycle_tick,
    input  wire logic            skip_next,
    input  wire irq_pkg::pc_t    next_pc,
    input  wire logic            return_from_irq_instruction_exec,
    input  wire logic            vis_exec,
    output logic                 ack_busy,
    output logic                 push_req,
    output irq_pkg::pc_t         push_addr,
    output logic                 pc_load,
    output irq_pkg::pc_t         pc_value,
    output logic                 pop_req,
    output logic [7:0]           vis_offset
);
    import irq_pkg::*;

    src_vec_t   enable;
    src_vec_t   pending;
    src_vec_t   active;
    logic       global_irq_enable_bit;
    logic       trap_pend;
    logic       trap_busy;
    ack_state_e state;
    logic [2:0] ack_cnt;
    logic       take;
    logic       take_trap;
    logic       maskable_ok;

    // Register write decode, shared by several concerns
    function automatic logic wr_hit(input logic [2:0] a,
                                    input logic [2:0] target,
                                    input logic       strobe);
        wr_hit = strobe && (a == target);
    endfunction

    // Vector table offset for the highest active source
    function automatic logic [7:0] pick_vector(input src_vec_t act);
        logic [79:0] table_bits;
        table_bits  = `VEC_TABLE;
        pick_vector = `VEC_DEFAULT;
        for (int i = `NUM_MASKABLE - 1; i >= 0; i--) begin
            if (act[i]) begin
                pick_vector = table_bits[i*8 +: 8];
            end
        end
    endfunction

    assign active = enable & pending;
    // Trap routine holds off every maskable source
    assign maskable_ok = global_irq_enable_bit && !trap_busy && (|active);
    // Only at an unskipped boundary while idle
    assign take = ce && instr_start && !skip_next && (state == ST_IDLE)
                  && (trap_pend || maskable_ok);
    assign take_trap = take && trap_pend;
    assign ack_busy = (state == ST_ACK);

    // Enable bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable <= '0;
        end else if (ce) begin
            if (wr_hit(addr, `ADDR_ENABLE_LO, wr)) begin
                enable[7:0] <= wdata;
            end
            if (wr_hit(addr, `ADDR_ENABLE_HI, wr)) begin
                enable[9:8] <= wdata[1:0];
            end
        end
    end

    // Pending flags: an event in the clearing cycle wins
    generate
        for (genvar g = 0; g < `NUM_MASKABLE; g++) begin : g_pend
            localparam logic [2:0] PADDR =
                (g < 8) ? `ADDR_PEND_LO : `ADDR_PEND_HI;
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pending[g] <= 1'b0;
                end else if (ce) begin
                    if (src_event[g]) begin
                        pending[g] <= 1'b1;
                    end else if (wr_hit(addr, PADDR, wr)) begin
                        pending[g] <= wdata[g % 8];
                    end
                end
            end
        end
    endgenerate

    // Global enable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_enable_bit <= 1'b0;
        end else if (ce) begin
            if (take) begin
                global_irq_enable_bit <= 1'b0;
            end else if (return_from_irq_instruction_exec) begin
                global_irq_enable_bit <= 1'b1;
            end else if (wr_hit(addr, `ADDR_STATUS, wr)) begin
                global_irq_enable_bit <= wdata[`STAT_GIE_BIT];
            end
        end
    end

    // Software trap request and in-service flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_pend <= 1'b0;
            trap_busy <= 1'b0;
        end else if (ce) begin
            // A trap issued in the take cycle must not be lost
            if (trap_exec) begin
                trap_pend <= 1'b1;
            end else if (take_trap) begin
                trap_pend <= 1'b0;
            end
            if (take_trap) begin
                trap_busy <= 1'b1;
            end else if (return_from_irq_instruction_exec) begin
                trap_busy <= 1'b0;
            end
        end
    end

    // Acknowledgment sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= ST_IDLE;
            ack_cnt <= '0;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        state   <= ST_ACK;
                        ack_cnt <= '0;
                    end
                end
                ST_ACK: begin
                    if (cycle_tick) begin
                        if (ack_cnt == `ACK_CYCLES - 3'h1) begin
                            state <= ST_IDLE;
                        end
                        ack_cnt <= ack_cnt + 3'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Core strobes; the push carries the address about to execute
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            push_req  <= 1'b0;
            push_addr <= '0;
            pc_load   <= 1'b0;
            pc_value  <= '0;
            pop_req   <= 1'b0;
        end else if (ce) begin
            push_req <= take;
            if (take) begin
                push_addr <= next_pc;
            end
            pc_load <= (state == ST_ACK) && cycle_tick
                       && (ack_cnt == `ACK_CYCLES - 3'h1);
            pc_value <= `ENTRY_ADDR;
            pop_req  <= return_from_irq_instruction_exec;
        end else begin
            push_req <= 1'b0;
            pc_load  <= 1'b0;
            pop_req  <= 1'b0;
        end
    end

    // Vector select result; trap outranks every maskable source
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vis_offset <= `VEC_DEFAULT;
        end else if (ce && vis_exec) begin
            if (trap_busy) begin
                vis_offset <= `VEC_TRAP;
            end else begin
                vis_offset <= pick_vector(active);
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd) begin
                case (addr)
                    `ADDR_ENABLE_LO: rdata <= enable[7:0];
                    `ADDR_ENABLE_HI: rdata <= {6'h00, enable[9:8]};
                    `ADDR_PEND_LO:   rdata <= pending[7:0];
                    `ADDR_PEND_HI:   rdata <= {6'h00, pending[9:8]};
                    `ADDR_STATUS:    rdata <= {5'h00, ack_busy,
                                               trap_busy, global_irq_enable_bit};
                    `ADDR_VECTOR:    rdata <= vis_offset;
                    default:         rdata <= '0;
                endcase
            end
        end
    end

    // Ticks seen during acknowledgment, kept apart from the sequencer
    // so that the length check does not trust its own counter
    logic [3:0] ack_ticks_seen;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ticks_seen <= '0;
        end else if (ce) begin
            if (take) begin
                ack_ticks_seen <= '0;
            end else if (ack_busy && cycle_tick) begin
                ack_ticks_seen <= ack_ticks_seen + 4'h1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_take_gie_clear: assert property (
        take |=> !global_irq_enable_bit) else $error("global enable not cleared on take");
    a_push_next_pc: assert property (
        take |=> push_req && push_addr == $past(next_pc))
        else $error("push missing or wrong address");
    a_entry_addr: assert property (
        pc_load |-> pc_value == `ENTRY_ADDR)
        else $error("entry address wrong");
    a_no_mid_take: assert property (
        !instr_start |-> !take) else $error("take off a boundary");
    a_skip_first: assert property (
        skip_next |-> !take) else $error("take during a skip");
    a_trap_blocks: assert property (
        ce && instr_start && trap_busy && !trap_pend |-> !take)
        else $error("maskable taken in trap routine");
    a_event_sets: assert property (
        ce && src_event[0] |=> pending[0])
        else $error("event did not set pending");
    a_enable_fires: assert property (
        ce && instr_start && !skip_next && state == ST_IDLE && global_irq_enable_bit
        && !trap_busy && (|active) |-> take)
        else $error("active source not taken");
    a_return_from_irq_instruction_gie: assert property (
        ce && return_from_irq_instruction_exec && !take |=> global_irq_enable_bit && pop_req)
        else $error("return did not restore enable");
    a_vis_rank: assert property (
        ce && vis_exec && !trap_busy && active[0] |=> vis_offset == 8'hFA)
        else $error("top source not selected");
    a_ack_len: assert property (
        pc_load |-> ack_ticks_seen == {1'b0, `ACK_CYCLES})
        else $error("acknowledgment length wrong");
    a_ack_bound: assert property (
        ack_busy |-> ack_ticks_seen < {1'b0, `ACK_CYCLES})
        else $error("acknowledgment overran its cycles");
    a_others_stay: assert property (
        take && !wr |=> (pending & $past(pending)) == $past(pending))
        else $error("pending flag lost at take");
    a_trap_first: assert property (
        take_trap && !trap_exec |=> trap_busy && !trap_pend)
        else $error("trap not taken first");
    a_vis_default: assert property (
        ce && vis_exec && !trap_busy && !(|active)
        |=> vis_offset == `VEC_DEFAULT)
        else $error("default vector not selected");
    a_vis_trap: assert property (
        ce && vis_exec && trap_busy |=> vis_offset == `VEC_TRAP)
        else $error("trap vector not selected");

    c_maskable_take: cover property (take && !trap_pend);
    c_trap_take: cover property (take_trap);
    c_nested: cover property (take ##[1:40] take);
    c_default_vis: cover property (vis_exec && !(|active) && !trap_busy);
    c_trap_done: cover property (pc_load && trap_busy);

endmodule // vectored_interrupt_arbiter

// ==== test/core_model.sv ====
// Core sequencer model: boundaries, ticks and return stack
`timescale 1ns/1ns
module core_model (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // From the arbiter
    input  wire logic         ack_busy,
    input  wire logic         push_req,
    input  wire irq_pkg::pc_t push_addr,
    input  wire logic         pop_req,
    // To the arbiter
    output logic              instr_start,
    output logic              cycle_tick,
    output irq_pkg::pc_t      next_pc
);
    import irq_pkg::*;

    logic [1:0] ph;
    pc_t        stk[$];
    // Ticks land on odd phases, never on a boundary edge
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph <= 2'h0;
            instr_start <= 1'b0;
            cycle_tick <= 1'b0;
            next_pc <= 15'h0100;
        end else begin
            ph <= ph + 2'h1;
            instr_start <= (ph == 2'h3) && !ack_busy;
            cycle_tick <= !ph[0];
            if (push_req) stk.push_back(push_addr);
            if (pop_req && stk.size() > 0) next_pc <= stk.pop_back();
            else if (instr_start) next_pc <= next_pc + 15'h1;
        end
    end
endmodule // core_model

// ==== test/vectored_interrupt_arbiter_bench.sv ====
// Self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ns
`include "irq_consts.svh"
module vectored_interrupt_arbiter_bench;
    import irq_pkg::*;
    logic ref_clk, rst_b, ce, wr, rd, skip_next, instr_start, cycle_tick;
    logic ack_busy, push_req, pc_load, pop_req;
    logic [2:0] addr, ctl;
    logic [7:0] wdata, rdata, vis_offset, d;
    src_vec_t   src_event;
    pc_t        next_pc, push_addr, pc_value, pc_prev;
    logic [31:0] seed = 32'h38, r;
    int fails = 0, num_checks = 0, cyc = 0, takes = 0, pops = 0, ticks = 0;

    vectored_interrupt_arbiter i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_event(src_event), .trap_exec(ctl[2]),
        .instr_start(instr_start), .cycle_tick(cycle_tick),
        .skip_next(skip_next), .next_pc(next_pc), .return_from_irq_instruction_exec(ctl[1]),
        .vis_exec(ctl[0]), .ack_busy(ack_busy), .push_req(push_req),
        .push_addr(push_addr), .pc_load(pc_load), .pc_value(pc_value),
        .pop_req(pop_req), .vis_offset(vis_offset));
    core_model i_core (.ref_clk(ref_clk), .rst_b(rst_b),
        .ack_busy(ack_busy), .push_req(push_req), .push_addr(push_addr),
        .pop_req(pop_req), .instr_start(instr_start),
        .cycle_tick(cycle_tick), .next_pc(next_pc));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Highest rank is bit 0; Port L sits alone at the bottom
    function automatic logic [7:0] exp_vis(input logic [9:0] m);
        exp_vis = `VEC_DEFAULT;
        for (int i = 9; i >= 0; i--)
            if (m[i]) exp_vis = (i == 9) ? 8'hE2 : 8'hFA - 8'(2 * i);
    endfunction
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
        @(posedge ref_clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge ref_clk) begin rd <= 1'b1; addr <= a; end
        @(posedge ref_clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge ref_clk) ctl <= v;
        @(posedge ref_clk) ctl <= 3'h0;
    endtask
    task automatic ev(input src_vec_t m);
        @(posedge ref_clk) src_event <= m;
        @(posedge ref_clk) src_event <= '0;
    endtask
    task automatic wait_ld();
        int n;
        for (n = 0; n < 400 && pc_load !== 1'b1; n++) @(posedge ref_clk);
        chk(n < 400, 1);
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pc_prev <= next_pc;
        if (pop_req === 1'b1) pops <= pops + 1;
        if (push_req === 1'b1) begin
            takes <= takes + 1;
            ticks <= int'(cycle_tick);
            chk(push_addr, pc_prev);
            chk(ack_busy, 1);
        end else if (ack_busy && cycle_tick) ticks <= ticks + 1;
        if (pc_load === 1'b1) begin
            chk(ticks, 7);
            chk(ack_busy, 0);
            chk(pc_value, `ENTRY_ADDR);
        end
        if (cyc == 6000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        {rst_b, ce, wr, rd, skip_next, addr, wdata, ctl, src_event} = '0;
        ce = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd_reg(3'(a));
            chk(d, 0);
        end
        chk(vis_offset, `VEC_DEFAULT);
        rd_reg(3'h7);
        chk(d, 0);
        // Clock enable low must freeze the registers
        @(posedge ref_clk) ce <= 1'b0;
        wr_reg(`ADDR_ENABLE_LO, 8'hFF);
        ce <= 1'b1;
        rd_reg(`ADDR_ENABLE_LO);
        chk(d, 0);
        // Global enable off: select only, corners first
        for (int n = 0; n < 27; n++) begin
            r = (n == 0) ? 32'hFFFFF : (n == 1) ? 32'h80200 :
                (n == 2) ? 32'h003FF : xs();
            ev(r[9:0]);
            wr_reg(`ADDR_ENABLE_LO, r[17:10]);
            wr_reg(`ADDR_ENABLE_HI, {6'h0, r[19:18]});
            rd_reg(`ADDR_PEND_LO);
            chk(d, r[7:0]);
            pulse(3'h1);
            #1 chk(vis_offset, exp_vis(r[9:0] & r[19:10]));
            wr_reg(`ADDR_PEND_LO, 8'h0);
            wr_reg(`ADDR_PEND_HI, 8'h0);
        end
        chk(takes, 0);
        wr_reg(`ADDR_ENABLE_LO, 8'h0);
        wr_reg(`ADDR_ENABLE_HI, 8'h0);
        ev(10'h020);
        wr_reg(`ADDR_STATUS, 8'h1);
        repeat (12) @(posedge ref_clk);
        chk(takes, 0);
        skip_next <= 1'b1;
        wr_reg(`ADDR_ENABLE_LO, 8'h20);
        repeat (12) @(posedge ref_clk);
        chk(takes, 0);
        skip_next <= 1'b0;
        wait_ld();
        chk(takes, 1);
        rd_reg(`ADDR_STATUS);
        chk(d, 0);
        wr_reg(`ADDR_PEND_LO, 8'h0);
        ev(10'h020);
        pulse(3'h2);
        wait_ld();
        chk(takes, 2);
        chk(pops, 1);
        // Stale flags go before the enable is set
        wr_reg(`ADDR_PEND_LO, 8'h0);
        wr_reg(`ADDR_ENABLE_LO, 8'h21);
        ev(10'h001);
        wr_reg(`ADDR_STATUS, 8'h1);
        wait_ld();
        chk(takes, 3);
        wr_reg(`ADDR_PEND_LO, 8'h0);
        pulse(3'h4);
        wait_ld();
        rd_reg(`ADDR_STATUS);
        chk(d, 8'h02);
        pulse(3'h1);
        #1 chk(vis_offset, `VEC_TRAP);
        ev(10'h001);
        wr_reg(`ADDR_STATUS, 8'h1);
        repeat (12) @(posedge ref_clk);
        chk(takes, 4);
        pulse(3'h2);
        wait_ld();
        chk(takes, 5);
        // Reset in mid-run clears everything again
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd_reg(3'(a));
            chk(d, 0);
        end
        chk(vis_offset, `VEC_DEFAULT);
        conclude();
    end
endmodule // vectored_interrupt_arbiter_bench
